// ---- rtl/pci_side_defines.svh ----
// Constants for the PCI-side bus interface.
`ifndef PCI_SIDE_DEFINES_SVH
`define PCI_SIDE_DEFINES_SVH
`define CMD_CFG_RD   4'hA
`define CMD_CFG_WR   4'hB
`define CMD_WR_BIT   0
`define TGT_BASE     32'h0000_0300
`define TGT_MASK     32'hFFFF_FFF0
`define SUB_DLY      3'h3
`define MABORT_CYC   3'h5
`define CNT_ONE      3'h1
`define AD_STEP      32'h0000_0004
`endif

// ---- rtl/pci_side_pkg.sv ----
// Types shared by the PCI-side bus interface.
package pci_side_pkg;
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_ADDR = 2'b01,
    M_DATA = 2'b10,
    M_TURN = 2'b11
  } mst_state_e;

  typedef enum logic [1:0] {
    T_IDLE = 2'b00,
    T_WAIT = 2'b01,
    T_DATA = 2'b10,
    T_TURN = 2'b11
  } tgt_state_e;

  typedef struct packed {
    logic [3:0]  cmd;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0]  be_n;
  } xfer_s;

  typedef struct packed {
    logic [31:0] ad;
    logic [3:0]  cbe_n;
    logic        frame_n;
    logic        irdy_n;
    logic        trdy_n;
    logic        stop_n;
    logic        devsel_n;
    logic        idsel;
  } bus_in_s;

  typedef struct packed {
    logic [31:0] ad;
    logic        ad_oe;
    logic [3:0]  cbe_n;
    logic        cbe_oe;
    logic        frame_n;
    logic        frame_oe;
    logic        irdy_n;
    logic        irdy_oe;
    logic        trdy_n;
    logic        trdy_oe;
    logic        stop_n;
    logic        stop_oe;
    logic        devsel_n;
    logic        devsel_oe;
  } bus_out_s;

  typedef struct packed {
    mst_state_e  st;
    logic [2:0]  cnt;
    xfer_s       x;
    bus_out_s    drv;
    logic        done;
    logic        retry;
    logic        abort;
  } mst_s;

  typedef struct packed {
    tgt_state_e  st;
    logic [2:0]  cnt;
    logic        wr;
    logic        sel;
    xfer_s       x;
    bus_out_s    drv;
    logic        strobe;
  } tgt_s;
endpackage

// ---- rtl/pci_side_bus_interface.sv ----
// PCI-side initiator and target bus interface of a PCI-to-ISA bridge.
//
// Overview of operation
// - AD carries the address in the first clock and data afterwards.
// - As initiator we drive AD for address and write data, float on read.
// - As target we sample AD on address and write, drive it on read.
// - C/BE carries the command in the address phase, byte enables after.
// - C/BE is driven only while initiator and is an input as target.
// - Configuration cycles are claimed only with the ID select high.
// - The initiator frames the cycle and drops frame on the last phase.
// - As target frame is only sampled, for start and last phase.
// - Initiator-ready marks valid write data or readiness for read data.
// - As target a transfer waits for initiator-ready from the far side.
// - A data phase completes only when both ready lines are asserted.
// - Frame, ready, stop and select lines are driven high one clock before they float; AD and C/BE float at once.
// - Device select comes one cycle after frame, or four if subtractive.
// - Target-ready shows read data placed or readiness for write data.
// - Stop with target-ready disconnects, stop alone asks for a retry.
`timescale 1ns/100ps
`include "pci_side_defines.svh"

module pci_side_bus_interface (
  input  wire logic                i_mclk,
  input  wire logic                i_rst,
  input  wire logic                i_ce,
  input  wire logic [31:0]         i_ad,
  input  wire logic [3:0]          i_cbe_n,
  input  wire logic                i_frame_n,
  input  wire logic                i_irdy_n,
  input  wire logic                i_trdy_n,
  input  wire logic                i_stop_n,
  input  wire logic                i_devsel_n,
  input  wire logic                i_idsel,
  output logic [31:0]              o_ad,
  output logic                     o_ad_oe,
  output logic [3:0]               o_cbe_n,
  output logic                     o_cbe_oe,
  output logic                     o_frame_n,
  output logic                     o_frame_oe,
  output logic                     o_irdy_n,
  output logic                     o_irdy_oe,
  output logic                     o_trdy_n,
  output logic                     o_trdy_oe,
  output logic                     o_stop_n,
  output logic                     o_stop_oe,
  output logic                     o_devsel_n,
  output logic                     o_devsel_oe,
  input  wire logic                i_mst_req,
  input  wire pci_side_pkg::xfer_s i_mst_xfer,
  output logic                     o_mst_busy,
  output logic                     o_mst_done,
  output logic                     o_mst_retry,
  output logic                     o_mst_abort,
  output logic [31:0]              o_mst_rdata,
  input  wire logic                i_sub_en,
  input  wire logic [1:0]          i_sub_point,
  input  wire logic                i_tgt_ready,
  input  wire logic                i_tgt_retry,
  input  wire logic                i_tgt_disc,
  input  wire logic [31:0]         i_tgt_rdata,
  output logic                     o_tgt_strobe,
  output pci_side_pkg::xfer_s      o_tgt_acc
);

  function automatic pci_side_pkg::bus_out_s idle_drv();
    pci_side_pkg::bus_out_s d;
    d          = '0;
    d.frame_n  = 1'b1;
    d.irdy_n   = 1'b1;
    d.trdy_n   = 1'b1;
    d.stop_n   = 1'b1;
    d.devsel_n = 1'b1;
    return d;
  endfunction

  function automatic logic is_cfg(logic [3:0] cmd);
    return (cmd == `CMD_CFG_RD) || (cmd == `CMD_CFG_WR);
  endfunction

  // ==========================================================================
  // Input synchronisers
  pci_side_pkg::bus_in_s pin_meta;
  pci_side_pkg::bus_in_s sy;
  logic                  frame_prev_n;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      pin_meta     <= '1;
      sy           <= '1;
      frame_prev_n <= 1'b1;
    end else if (i_ce) begin
      pin_meta     <= {i_ad, i_cbe_n, i_frame_n, i_irdy_n, i_trdy_n,
                       i_stop_n, i_devsel_n, i_idsel};
      sy           <= pin_meta;
      frame_prev_n <= sy.frame_n;
    end
  end

  // ==========================================================================
  // Initiator
  pci_side_pkg::mst_s m;
  pci_side_pkg::mst_s next_m;
  pci_side_pkg::tgt_s t;
  pci_side_pkg::tgt_s next_t;
  logic               bus_idle;
  logic               mst_busy;
  logic               next_mst_busy;
  logic [31:0]        mst_rdata;
  logic [31:0]        next_mst_rdata;

  assign bus_idle = sy.frame_n && sy.irdy_n;

  always_comb begin
    next_m         = m;
    next_m.done    = 1'b0;
    next_m.retry   = 1'b0;
    next_m.abort   = 1'b0;
    next_mst_rdata = mst_rdata;
    case (m.st)
      pci_side_pkg::M_IDLE: begin
        if (i_mst_req && bus_idle && (t.st == pci_side_pkg::T_IDLE)) begin
          next_m.x            = i_mst_xfer;
          next_m.drv          = idle_drv();
          next_m.drv.ad       = i_mst_xfer.addr;
          next_m.drv.ad_oe    = 1'b1;
          next_m.drv.cbe_n    = i_mst_xfer.cmd;
          next_m.drv.cbe_oe   = 1'b1;
          next_m.drv.frame_n  = 1'b0;
          next_m.drv.frame_oe = 1'b1;
          next_m.drv.irdy_oe  = 1'b1;
          next_m.st           = pci_side_pkg::M_ADDR;
        end
      end
      pci_side_pkg::M_ADDR: begin
        next_m.drv.ad      = m.x.cmd[`CMD_WR_BIT] ? m.x.data : '0;
        next_m.drv.ad_oe   = m.x.cmd[`CMD_WR_BIT];
        next_m.drv.cbe_n   = m.x.be_n;
        next_m.drv.frame_n = 1'b1;
        next_m.drv.irdy_n  = 1'b0;
        next_m.cnt         = '0;
        next_m.st          = pci_side_pkg::M_DATA;
      end
      pci_side_pkg::M_DATA: begin
        if (m.cnt != `MABORT_CYC) begin
          next_m.cnt = m.cnt + `CNT_ONE;
        end
        if (!sy.trdy_n && !m.drv.irdy_n) begin
          next_m.done    = 1'b1;
          next_mst_rdata = sy.ad;
        end else if (!sy.stop_n) begin
          next_m.retry   = 1'b1;
        end else if (sy.devsel_n && (m.cnt == `MABORT_CYC)) begin
          next_m.abort   = 1'b1;
        end
        if (next_m.done || next_m.retry || next_m.abort) begin
          next_m.drv.irdy_n   = 1'b1;
          next_m.drv.ad_oe    = 1'b0;
          next_m.drv.cbe_oe   = 1'b0;
          next_m.drv.frame_oe = 1'b0;
          next_m.st           = pci_side_pkg::M_TURN;
        end
      end
      pci_side_pkg::M_TURN: begin
        next_m.drv = idle_drv();
        next_m.st  = pci_side_pkg::M_IDLE;
      end
      default: begin
        next_m = '0;
      end
    endcase
    next_mst_busy = (next_m.st != pci_side_pkg::M_IDLE);
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      m         <= '0;
      mst_rdata <= '0;
      mst_busy  <= 1'b0;
    end else if (i_ce) begin
      m         <= next_m;
      mst_rdata <= next_mst_rdata;
      mst_busy  <= next_mst_busy;
    end
  end

  // ==========================================================================
  // Target
  logic frame_fall;
  logic tgt_xfer;

  assign frame_fall = !sy.frame_n && frame_prev_n;
  assign tgt_xfer   = !t.drv.trdy_n && !sy.irdy_n;

  always_comb begin
    next_t        = t;
    next_t.strobe = 1'b0;
    case (t.st)
      pci_side_pkg::T_IDLE: begin
        next_t.drv = idle_drv();
        if (frame_fall && (m.st == pci_side_pkg::M_IDLE)) begin
          next_t.x.addr = sy.ad;
          next_t.x.cmd  = sy.cbe_n;
          next_t.wr     = sy.cbe_n[`CMD_WR_BIT];
          next_t.sel    = sy.idsel;
          next_t.cnt    = `CNT_ONE;
          if (is_cfg(sy.cbe_n) ? sy.idsel
              : ((sy.ad & `TGT_MASK) == `TGT_BASE)) begin
            next_t.drv.devsel_n  = 1'b0;
            next_t.drv.devsel_oe = 1'b1;
            next_t.drv.trdy_oe   = 1'b1;
            next_t.drv.stop_oe   = 1'b1;
            next_t.st            = pci_side_pkg::T_DATA;
          end else if (i_sub_en && !is_cfg(sy.cbe_n)) begin
            next_t.st            = pci_side_pkg::T_WAIT;
          end
        end
      end
      pci_side_pkg::T_WAIT: begin
        next_t.cnt = t.cnt + `CNT_ONE;
        if (!sy.devsel_n && (t.cnt <= {1'b0, i_sub_point})) begin
          next_t.st = pci_side_pkg::T_IDLE;
        end else if (t.cnt == `SUB_DLY) begin
          next_t.drv.devsel_n  = 1'b0;
          next_t.drv.devsel_oe = 1'b1;
          next_t.drv.trdy_oe   = 1'b1;
          next_t.drv.stop_oe   = 1'b1;
          next_t.st            = pci_side_pkg::T_DATA;
        end
      end
      pci_side_pkg::T_DATA: begin
        next_t.drv.ad     = i_tgt_rdata;
        next_t.drv.ad_oe  = !t.wr;
        next_t.drv.trdy_n = !(i_tgt_ready && !i_tgt_retry);
        next_t.drv.stop_n = !(i_tgt_retry || i_tgt_disc);
        if (tgt_xfer) begin
          next_t.strobe    = 1'b1;
          next_t.x.be_n    = sy.cbe_n;
          next_t.x.data    = t.wr ? sy.ad : t.drv.ad;
          next_t.x.addr    = t.x.addr + `AD_STEP;
        end
        if (sy.frame_n && (tgt_xfer || (!t.drv.stop_n && !sy.irdy_n))) begin
          next_t.drv.devsel_n = 1'b1;
          next_t.drv.trdy_n   = 1'b1;
          next_t.drv.stop_n   = 1'b1;
          next_t.drv.ad_oe    = 1'b0;
          next_t.st           = pci_side_pkg::T_TURN;
        end
      end
      pci_side_pkg::T_TURN: begin
        next_t.drv = idle_drv();
        next_t.st  = pci_side_pkg::T_IDLE;
      end
      default: begin
        next_t = '0;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      t <= '0;
    end else if (i_ce) begin
      t <= next_t;
    end
  end

  // ==========================================================================
  // Pin and user outputs
  pci_side_pkg::bus_out_s pin;
  pci_side_pkg::bus_out_s next_pin;

  always_comb begin
    next_pin = (next_m.st != pci_side_pkg::M_IDLE) ? next_m.drv : next_t.drv;
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      pin <= idle_drv();
    end else if (i_ce) begin
      pin <= next_pin;
    end
  end

  assign {o_ad, o_ad_oe, o_cbe_n, o_cbe_oe, o_frame_n, o_frame_oe,
          o_irdy_n, o_irdy_oe, o_trdy_n, o_trdy_oe, o_stop_n, o_stop_oe,
          o_devsel_n, o_devsel_oe} = pin;
  assign o_mst_busy   = mst_busy;
  assign o_mst_done   = m.done;
  assign o_mst_retry  = m.retry;
  assign o_mst_abort  = m.abort;
  assign o_mst_rdata  = mst_rdata;
  assign o_tgt_strobe = t.strobe;
  assign o_tgt_acc    = t.x;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst || !i_ce);

  a_mst_addr: assert property (m.st == pci_side_pkg::M_ADDR |->
    o_ad_oe && o_cbe_oe && !o_frame_n && (o_ad == m.x.addr))
    else $error("Address phase not driven by initiator.");
  a_mst_read_float: assert property ((m.st == pci_side_pkg::M_DATA)
    && !m.x.cmd[`CMD_WR_BIT] |-> !o_ad_oe)
    else $error("Initiator drives AD during read data.");
  a_cbe_owner: assert property (o_cbe_oe |->
    m.st != pci_side_pkg::M_IDLE)
    else $error("C/BE driven while not initiator.");
  a_cfg_idsel: assert property ((t.st == pci_side_pkg::T_DATA)
    && is_cfg(t.x.cmd) |-> t.sel)
    else $error("Configuration cycle claimed without select.");
  a_frame_last: assert property ($rose(m.st == pci_side_pkg::M_DATA) |->
    o_frame_n && !o_irdy_n && $past(!o_frame_n))
    else $error("Frame not released on final data phase.");
  a_frame_input: assert property (t.st != pci_side_pkg::T_IDLE |->
    !o_frame_oe && !o_cbe_oe)
    else $error("Target drives frame or C/BE.");
  a_xfer_both: assert property (t.strobe |->
    $past(!o_trdy_n && !sy.irdy_n))
    else $error("Target transfer without both ready lines.");
  a_devsel_fast: assert property ((t.st == pci_side_pkg::T_IDLE)
    ##1 (t.st == pci_side_pkg::T_DATA) |-> !o_devsel_n)
    else $error("Device select late on positive decode.");
  a_devsel_sub: assert property ($rose(t.st == pci_side_pkg::T_WAIT) |->
    o_devsel_n[*3] ##1 (t.st != pci_side_pkg::T_DATA
    || !o_devsel_n))
    else $error("Subtractive device select at wrong cycle.");
  a_release_high: assert property ($fell(o_devsel_oe) || $fell(o_irdy_oe)
    |-> $past(o_devsel_n && o_irdy_n))
    else $error("Line floated without being driven high.");
  a_read_drive: assert property ((t.st == pci_side_pkg::T_DATA) && !t.wr
    && !o_trdy_n |-> o_ad_oe)
    else $error("Target ready on read without data driven.");
  a_retry_code: assert property ((t.st == pci_side_pkg::T_DATA)
    && $past(i_tgt_retry) && $past(t.st == pci_side_pkg::T_DATA)
    |-> !o_stop_n && o_trdy_n)
    else $error("Retry not signalled as stop without ready.");

  c_mst_write: cover property (m.done && m.x.cmd[`CMD_WR_BIT]);
  c_mst_read: cover property (m.done && !m.x.cmd[`CMD_WR_BIT]);
  c_tgt_sub: cover property ((t.st == pci_side_pkg::T_WAIT)
    ##1 (t.st == pci_side_pkg::T_DATA));
  c_tgt_retry: cover property (!o_stop_n && o_trdy_n);

endmodule // pci_side_bus_interface

// ---- dv/far_agent.sv ----
// Far-side bus agent model for the PCI-side bus interface bench.
`timescale 1ns/100ps
module far_agent (
  input  wire pci_side_pkg::bus_in_s i_bus,
  input  wire logic                  i_mclk,
  output pci_side_pkg::bus_out_s     o_drv,
  output logic                       o_idsel
);
  initial begin
    o_drv   = '0;
    o_idsel = 1'b0;
  end

  task automatic tpins(input logic dv, input logic tr, input logic oe);
    o_drv.devsel_n  <= dv;
    o_drv.trdy_n    <= tr;
    o_drv.stop_n    <= 1'b1;
    o_drv.devsel_oe <= oe;
    o_drv.trdy_oe   <= oe;
    o_drv.stop_oe   <= oe;
  endtask

  // ====================================================================
  // Target role: mode 0 completes, mode 1 asks a retry, mode 2 is silent.
  task automatic serve(input int mode, input logic [31:0] rd,
                       output pci_side_pkg::xfer_s got);
    int n;
    got = '0;
    for (n = 0; n < 40 && i_bus.frame_n !== 1'b0; n++) @(posedge i_mclk);
    got.addr = i_bus.ad;
    got.cmd  = i_bus.cbe_n;
    if (mode == 2)
      return;
    tpins(1'b0, 1'b1, 1'b1);
    repeat (2) @(posedge i_mclk);
    o_drv.stop_n <= mode != 1;
    o_drv.trdy_n <= mode == 1;
    o_drv.ad     <= rd;
    o_drv.ad_oe  <= mode == 0 && !got.cmd[0];
    for (n = 0; n < 40; n++) begin
      @(posedge i_mclk);
      if (mode == 0 && i_bus.irdy_n === 1'b0 && i_bus.trdy_n === 1'b0) break;
      if (mode == 1 && i_bus.irdy_n === 1'b1) break;
    end
    got.data = i_bus.ad;
    got.be_n = i_bus.cbe_n;
    tpins(1'b1, 1'b1, 1'b1);
    o_drv.ad_oe <= 1'b0;
    @(posedge i_mclk);
    tpins(1'b1, 1'b1, 1'b0);
  endtask

  // ====================================================================
  // Initiator role: res 0 unclaimed, 1 transferred, 2 retried.
  task automatic start(input pci_side_pkg::xfer_s x, input logic sel,
                       input int iw, output logic [31:0] rd,
                       output int dly, output int res);
    int k;
    dly = 0;
    res = 0;
    o_drv.frame_n  <= 1'b0;
    o_drv.frame_oe <= 1'b1;
    o_drv.irdy_n   <= 1'b1;
    o_drv.irdy_oe  <= 1'b1;
    o_drv.ad       <= x.addr;
    o_drv.ad_oe    <= 1'b1;
    o_drv.cbe_n    <= x.cmd;
    o_drv.cbe_oe   <= 1'b1;
    o_idsel        <= sel;
    for (k = 1; k < 40 && res == 0; k++) begin
      @(posedge i_mclk);
      if (i_bus.devsel_n === 1'b0 && dly == 0) dly = k;
      if (k > iw && i_bus.irdy_n === 1'b0 && i_bus.trdy_n === 1'b0) res = 1;
      if (k > iw && i_bus.stop_n === 1'b0 && i_bus.trdy_n !== 1'b0) res = 2;
      if (k == 1) begin
        o_idsel     <= 1'b0;
        o_drv.ad    <= x.data;
        o_drv.ad_oe <= x.cmd[0];
        o_drv.cbe_n <= x.be_n;
      end
      if (k == iw) begin
        o_drv.frame_n <= 1'b1;
        o_drv.irdy_n  <= 1'b0;
      end
    end
    rd = i_bus.ad;
    o_drv.irdy_n <= 1'b1;
    o_drv.ad_oe  <= 1'b0;
    o_drv.cbe_oe <= 1'b0;
    @(posedge i_mclk);
    o_drv.frame_oe <= 1'b0;
    o_drv.irdy_oe  <= 1'b0;
  endtask
endmodule // far_agent

// ---- dv/tb_top.sv ----
// Self-checking bench for the PCI-side bus interface.
`timescale 1ns/100ps
module tb_top;
  logic                   i_mclk = 1'b0;
  logic                   i_rst = 1'b1;
  logic                   i_mst_req = 1'b0;
  pci_side_pkg::xfer_s    i_mst_xfer = '0;
  logic                   i_sub_en = 1'b0;
  logic                   i_tgt_retry = 1'b0;
  logic                   i_tgt_ready = 1'b1;
  logic                   i_tgt_disc = 1'b0;
  logic [31:0]            o_ad;
  logic [31:0]            o_mst_rdata;
  logic [3:0]             o_cbe_n;
  logic                   o_ad_oe, o_cbe_oe, o_frame_n, o_frame_oe;
  logic                   o_irdy_n, o_irdy_oe, o_trdy_n, o_trdy_oe;
  logic                   o_stop_n, o_stop_oe, o_devsel_n, o_devsel_oe;
  logic                   o_mst_busy, o_mst_done, o_mst_retry, o_mst_abort;
  logic                   o_tgt_strobe;
  pci_side_pkg::xfer_s    o_tgt_acc, acc;
  pci_side_pkg::bus_out_s far;
  pci_side_pkg::bus_in_s  bus;
  logic                   far_idsel;
  int errors = 0, cmp_count = 0, n_done = 0, n_retry = 0, n_abort = 0;
  int n_strb = 0, n_clash = 0, pos_dly = 0, n_disc = 0;

  always #5 i_mclk = ~i_mclk;

  assign bus.ad = o_ad_oe ? o_ad : far.ad_oe ? far.ad : 32'hFFFF_FFFF;
  assign bus.cbe_n = o_cbe_oe ? o_cbe_n : far.cbe_oe ? far.cbe_n : 4'hF;
  assign bus.frame_n = o_frame_oe ? o_frame_n :
                       far.frame_oe ? far.frame_n : 1'b1;
  assign bus.irdy_n = o_irdy_oe ? o_irdy_n : far.irdy_oe ? far.irdy_n : 1'b1;
  assign bus.trdy_n = o_trdy_oe ? o_trdy_n : far.trdy_oe ? far.trdy_n : 1'b1;
  assign bus.stop_n = o_stop_oe ? o_stop_n : far.stop_oe ? far.stop_n : 1'b1;
  assign bus.devsel_n = o_devsel_oe ? o_devsel_n :
                        far.devsel_oe ? far.devsel_n : 1'b1;
  assign bus.idsel = far_idsel;

  pci_side_bus_interface i_pci_side_bus_interface (
    .i_mclk, .i_rst, .i_ce(1'b1), .i_ad(bus.ad), .i_cbe_n(bus.cbe_n),
    .i_frame_n(bus.frame_n), .i_irdy_n(bus.irdy_n), .i_trdy_n(bus.trdy_n),
    .i_stop_n(bus.stop_n), .i_devsel_n(bus.devsel_n), .i_idsel(bus.idsel),
    .o_ad, .o_ad_oe, .o_cbe_n, .o_cbe_oe, .o_frame_n, .o_frame_oe,
    .o_irdy_n, .o_irdy_oe, .o_trdy_n, .o_trdy_oe, .o_stop_n, .o_stop_oe,
    .o_devsel_n, .o_devsel_oe, .i_mst_req, .i_mst_xfer, .o_mst_busy,
    .o_mst_done, .o_mst_retry, .o_mst_abort, .o_mst_rdata, .i_sub_en,
    .i_sub_point(2'h3), .i_tgt_ready, .i_tgt_retry, .i_tgt_disc,
    .i_tgt_rdata(32'h89AB_CDEF), .o_tgt_strobe, .o_tgt_acc
  );
  far_agent i_far_agent (.i_bus(bus), .i_mclk, .o_drv(far),
                         .o_idsel(far_idsel));

  // Counts pulses and flags any line driven by both parties at once.
  always @(posedge i_mclk) begin
    if (o_mst_done === 1'b1) n_done++;
    if (o_mst_retry === 1'b1) n_retry++;
    if (o_mst_abort === 1'b1) n_abort++;
    if (o_tgt_strobe === 1'b1) n_strb++;
    if (o_tgt_strobe === 1'b1) acc = o_tgt_acc;
    if (o_stop_oe === 1'b1 && o_stop_n === 1'b0 && o_trdy_n === 1'b0)
      n_disc++;
    if (|({o_ad_oe, o_cbe_oe, o_frame_oe, o_irdy_oe, o_trdy_oe, o_stop_oe,
           o_devsel_oe} & {far.ad_oe, far.cbe_oe, far.frame_oe, far.irdy_oe,
           far.trdy_oe, far.stop_oe, far.devsel_oe})) n_clash++;
  end

  // ====================================================================
  // Shared tasks.
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic mst_run(input int mode, input logic [3:0] cmd,
                         output pci_side_pkg::xfer_s got);
    int n;
    @(posedge i_mclk);
    i_mst_req  <= 1'b1;
    i_mst_xfer <= '{cmd: cmd, addr: 32'h0000_1000, data: 32'hA5A5_1234,
                    be_n: 4'h5};
    fork
      i_far_agent.serve(mode, 32'h1357_9BDF, got);
      begin
        for (n = 0; n < 20 && o_mst_busy !== 1'b1; n++) @(posedge i_mclk);
        i_mst_req <= 1'b0;
      end
    join
    chk("mst_busy", n < 20, 1);
    repeat (12) @(posedge i_mclk);
    #1;
    chk("mst_idle", o_mst_busy, 0);
  endtask

  task automatic tgt_run(input logic [3:0] cmd, input logic [31:0] addr,
                         input logic sel, input logic sub, input logic rty,
                         output logic [31:0] rd, output int dly,
                         output int res);
    @(posedge i_mclk);
    i_sub_en    <= sub;
    i_tgt_retry <= rty;
    i_far_agent.start('{cmd: cmd, addr: addr, data: 32'h0F1E_2D3C,
                        be_n: 4'hA}, sel, 3, rd, dly, res);
    repeat (8) @(posedge i_mclk);
    #1;
  endtask

  // ====================================================================
  // Scenarios.
  task automatic sc_mst_write();
    pci_side_pkg::xfer_s got;
    int d0 = n_done;
    mst_run(0, 4'h7, got);
    chk("mst_addr", got.addr, 32'h0000_1000);
    chk("mst_cmd", {28'h0, got.cmd}, 32'h7);
    chk("mst_wdata", got.data, 32'hA5A5_1234);
    chk("mst_be", {28'h0, got.be_n}, 32'h5);
    chk("mst_done", n_done - d0, 1);
  endtask

  task automatic sc_mst_read();
    pci_side_pkg::xfer_s got;
    int d0 = n_done;
    mst_run(0, 4'h6, got);
    chk("mst_rdata", o_mst_rdata, 32'h1357_9BDF);
    chk("mst_rd_done", n_done - d0, 1);
  endtask

  task automatic sc_mst_ends();
    pci_side_pkg::xfer_s got;
    int r0 = n_retry;
    int a0 = n_abort;
    mst_run(1, 4'h7, got);
    chk("mst_retry", n_retry - r0, 1);
    mst_run(2, 4'h6, got);
    chk("mst_abort", n_abort - a0, 1);
  endtask

  task automatic sc_tgt_data();
    logic [31:0] rd;
    int dly, res, s0;
    s0 = n_strb;
    tgt_run(4'h7, 32'h0000_0304, 1'b0, 1'b0, 1'b0, rd, pos_dly, res);
    chk("tw_res", res, 1);
    chk("tw_strobe", n_strb - s0, 1);
    chk("tw_data", acc.data, 32'h0F1E_2D3C);
    chk("tw_be", {28'h0, acc.be_n}, 32'hA);
    chk("tw_cmd", {28'h0, acc.cmd}, 32'h7);
    chk("tw_dly", pos_dly, 4);
    chk("tw_addr", acc.addr, 32'h0000_0308);
    tgt_run(4'h6, 32'h0000_0308, 1'b0, 1'b0, 1'b0, rd, dly, res);
    chk("tr_data", rd, 32'h89AB_CDEF);
  endtask

  task automatic sc_tgt_decode();
    logic [31:0] rd;
    int dly, res;
    tgt_run(4'hB, 32'h0000_0000, 1'b0, 1'b1, 1'b0, rd, dly, res);
    chk("cfg_nosel", res, 0);
    tgt_run(4'hB, 32'h0000_0000, 1'b1, 1'b0, 1'b0, rd, dly, res);
    chk("cfg_sel", res, 1);
    tgt_run(4'h7, 32'h0000_2000, 1'b0, 1'b0, 1'b0, rd, dly, res);
    chk("sub_off", res, 0);
    tgt_run(4'h7, 32'h0000_2000, 1'b0, 1'b1, 1'b0, rd, dly, res);
    chk("sub_dly", dly, pos_dly + 3);
    tgt_run(4'h6, 32'h0000_0300, 1'b0, 1'b0, 1'b1, rd, dly, res);
    chk("tgt_retry", res, 2);
  endtask

  task automatic sc_tgt_flow();
    logic [31:0] rd;
    int dly, res, s0, d0;
    s0 = n_strb;
    fork
      tgt_run(4'h7, 32'h0000_0300, 1'b0, 1'b0, 1'b0, rd, dly, res);
      begin
        @(posedge i_mclk);
        i_tgt_ready <= 1'b0;
        repeat (7) @(posedge i_mclk);
        chk("rdy_hold", o_trdy_n, 1);
        i_tgt_ready <= 1'b1;
      end
    join
    chk("rdy_res", res, 1);
    chk("rdy_strobe", n_strb - s0, 1);
    d0 = n_disc;
    fork
      tgt_run(4'h6, 32'h0000_0300, 1'b0, 1'b0, 1'b0, rd, dly, res);
      begin
        @(posedge i_mclk);
        i_tgt_disc <= 1'b1;
      end
    join
    @(posedge i_mclk);
    i_tgt_disc <= 1'b0;
    chk("disc_res", res, 1);
    chk("disc_stop", n_disc > d0, 1);
  endtask

  initial begin
    repeat (16) @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_mclk);
    sc_mst_write();
    sc_mst_read();
    sc_mst_ends();
    sc_tgt_data();
    sc_tgt_decode();
    sc_tgt_flow();
    chk("bus_clash", n_clash, 0);
    close_out();
  end

  initial begin
    #40000;
    errors++;
    close_out();
  end
endmodule // tb_top
